// *** pkg/pafs_regs.vh ***
// Register offsets, field positions and reset values for the port A pin-function block
`ifndef PAFS_REGS_VH
`define PAFS_REGS_VH

// Byte addresses of the two control registers
`define PAFS_LOW_ONE_ADDR   4'h0
`define PAFS_LOW_TWO_ADDR   4'h4

// Reset values of the control registers
`define PAFS_LOW_ONE_RESET  16'h0000
`define PAFS_LOW_TWO_RESET  16'h0000

// Field positions in the first low control register
`define PAFS_PIN_TEN_BIT    4
`define PAFS_PIN_NINE_HI    3
`define PAFS_PIN_NINE_LO    2
`define PAFS_PIN_EIGHT_HI   1
`define PAFS_PIN_EIGHT_LO   0

// Field positions in the second low control register
`define PAFS_PIN_SEVEN_HI   15
`define PAFS_PIN_SEVEN_LO   14

// Mode codes of the two-bit fields
`define PAFS_MODE_PORT      2'h0
`define PAFS_MODE_TIMER     2'h1
`define PAFS_MODE_IRQ       2'h2
`define PAFS_MODE_CS        2'h2

// Writable bit masks; all other bits read as zero
`define PAFS_LOW_ONE_MASK   16'h001F
`define PAFS_LOW_TWO_MASK   16'hC000

`endif

// *** hdl/pafs_pin_mux.v ***
// Port A pin-function selection for pins seven to ten with a Wishbone register slave
//
// How it works
// RULE1: pin nine: port, timer D, irq three
// RULE2: pin eight: port, timer C, irq two
// RULE3: pin seven: port, timer B, chip select
// RULE4: reg one bits 3:2 nine, 1:0 eight
// RULE5: reg two bits 15:14 pin seven mode
// RULE6: pin ten bit 4: port or cs0
// RULE7: software never writes the prohibited 11 code
//
// The register addresses and the Wishbone interface to the registers are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
`include "pafs_regs.vh"

// Bus side: a classic Wishbone slave with two 16-bit registers on a 32-bit
// bus. Pin side: four multiplexed pads, each handing its pad value to at most
// one consumer and taking its output from at most one source. The pin side is
// combinational from the mode registers, so a mode change takes effect right
// after the edge that stores the write.

module pafs_pin_mux #(
  parameter ADDR_W = 4                        // Word-aligned byte address width
) (
  // Clock and reset
  input  wire              clk,
  input  wire              rst_b,
  // Wishbone classic slave
  input  wire              wb_cyc_i,
  input  wire              wb_stb_i,
  input  wire              wb_we_i,
  input  wire [ADDR_W-1:0] wb_adr_i,
  input  wire [3:0]        wb_sel_i,
  input  wire [31:0]       wb_dat_i,
  output reg  [31:0]       wb_dat_o,
  output reg               wb_ack_o,
  output wire              wb_err_o,
  // Pin seven
  input  wire              port_pin_seven_i,
  output wire              port_pin_seven_o,
  output wire              port_pin_seven_oe,
  input  wire              port_out_seven,
  input  wire              port_oe_seven,
  output wire              port_in_seven,
  output wire              timer_ext_clock_b,
  input  wire              chip_select_three_b,
  // Pin eight
  input  wire              port_pin_eight_i,
  output wire              port_pin_eight_o,
  output wire              port_pin_eight_oe,
  input  wire              port_out_eight,
  input  wire              port_oe_eight,
  output wire              port_in_eight,
  output wire              timer_ext_clock_c,
  output wire              ext_interrupt_two,
  // Pin nine
  input  wire              port_pin_nine_i,
  output wire              port_pin_nine_o,
  output wire              port_pin_nine_oe,
  input  wire              port_out_nine,
  input  wire              port_oe_nine,
  output wire              port_in_nine,
  output wire              timer_ext_clock_d,
  output wire              ext_interrupt_three,
  // Pin ten
  input  wire              port_pin_ten_i,
  output wire              port_pin_ten_o,
  output wire              port_pin_ten_oe,
  input  wire              port_out_ten,
  input  wire              port_oe_ten,
  output wire              port_in_ten,
  input  wire              chip_select_zero_b
);

  // Control registers; only the mode fields are storage, the rest read zero
  reg  [15:0] port_a_low_control_one_reg;   // Pins eight to ten modes
  reg  [15:0] port_a_low_control_two_reg;   // Pin seven mode
  // Bus decode
  wire        req;                          // New bus request this cycle
  wire        hit_one;                      // Address decodes to register one
  wire        hit_two;                      // Address decodes to register two
  wire [15:0] wr_one_masked;                // Write data, unused bits of register one cleared
  wire [15:0] wr_two_masked;                // Write data, unused bits of register two cleared
  // Mode fields pulled out of the registers
  wire [1:0]  pin_nine_mode;                // Pin nine mode code
  wire [1:0]  pin_eight_mode;               // Pin eight mode code
  wire [1:0]  pin_seven_mode;               // Pin seven mode code
  wire        pin_ten_mode;                 // Pin ten: 0 port, 1 chip select zero
  // Pins eight (index 0) and nine (index 1) share one shape, gathered as vectors
  wire [3:0]  irq_pin_mode;                 // Two mode codes, pin eight in the low pair
  wire [1:0]  irq_pin_pad;                  // Pad inputs
  wire [1:0]  irq_pin_port_out;             // Port output values
  wire [1:0]  irq_pin_port_oe;              // Port output enables
  wire [1:0]  irq_pin_out;                  // Pad output values
  wire [1:0]  irq_pin_oe;                   // Pad output enables
  wire [1:0]  irq_pin_port_in;              // Pad value to the port logic
  wire [1:0]  irq_pin_timer;                // Pad value to the timer clock input
  wire [1:0]  irq_pin_irq;                  // Pad value to the interrupt input, idle high
  // Pin seven decoded selections
  wire        seven_is_port;                // Pin seven in port mode
  wire        seven_is_timer;               // Pin seven feeds timer clock B
  wire        seven_is_select;              // Pin seven drives chip select three
  genvar      i;                            // Pin index in the shared loop

  // Ack drops the cycle after it is given, so a held request is taken once.
  // Every request is answered, mapped or not, so a stray address cannot
  // hang the bus.
  assign req     = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  assign hit_one = (wb_adr_i == `PAFS_LOW_ONE_ADDR);
  assign hit_two = (wb_adr_i == `PAFS_LOW_TWO_ADDR);
  // Unmapped addresses still ack and read zero; no error path
  assign wb_err_o = 1'b0;

  // Field extraction; bit positions come from the shared register header so
  // that software headers and this logic cannot drift apart
  assign pin_nine_mode  = port_a_low_control_one_reg[`PAFS_PIN_NINE_HI:`PAFS_PIN_NINE_LO];   // RULE4
  assign pin_eight_mode = port_a_low_control_one_reg[`PAFS_PIN_EIGHT_HI:`PAFS_PIN_EIGHT_LO]; // RULE4
  assign pin_seven_mode = port_a_low_control_two_reg[`PAFS_PIN_SEVEN_HI:`PAFS_PIN_SEVEN_LO]; // RULE5
  assign pin_ten_mode   = port_a_low_control_one_reg[`PAFS_PIN_TEN_BIT];                     // RULE6

  // Mask before the byte lanes are picked, so unused bits never store a one
  // and both masks stay at full register width; the lane slice below then
  // takes exactly the bits that belong to the selected lane.
  assign wr_one_masked = wb_dat_i[15:0] & `PAFS_LOW_ONE_MASK; // RULE4
  assign wr_two_masked = wb_dat_i[15:0] & `PAFS_LOW_TWO_MASK; // RULE5

  // Register writes; registers are 16 bits so only byte lanes 0 and 1 matter.
  // Register one keeps its fields in lane 0 and register two in lane 1, so a
  // write that leaves that lane's select low leaves the fields untouched.
  // Writes land at the edge that takes the request; the master holds
  // everything until ack, so it cannot observe the earlier update.
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      port_a_low_control_one_reg <= `PAFS_LOW_ONE_RESET; // RULE4
      port_a_low_control_two_reg <= `PAFS_LOW_TWO_RESET; // RULE5
    end else if (req && wb_we_i) begin
      if (hit_one) begin
        if (wb_sel_i[0])
          port_a_low_control_one_reg[7:0] <= wr_one_masked[7:0]; // RULE4
      end
      if (hit_two) begin
        if (wb_sel_i[1])
          port_a_low_control_two_reg[15:8] <= wr_two_masked[15:8]; // RULE5
      end
    end
  end

  // Ack and read data, registered: answer one edge after the request is seen.
  // The master therefore sees ack at the second edge after it raised stb; a
  // stb still held after ack is not taken again because req masks on ack.
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h00000000;
    end else begin
      wb_ack_o <= req;
      // Read data is loaded only on reads, so it holds until the next read
      if (req && !wb_we_i) begin
        if (hit_one)
          wb_dat_o <= {16'h0000, port_a_low_control_one_reg};
        else if (hit_two)
          wb_dat_o <= {16'h0000, port_a_low_control_two_reg};
        else
          wb_dat_o <= 32'h00000000;
      end
    end
  end

  // Gather pins eight and nine so that one loop builds both
  assign irq_pin_mode     = {pin_nine_mode, pin_eight_mode};
  assign irq_pin_pad      = {port_pin_nine_i, port_pin_eight_i};
  assign irq_pin_port_out = {port_out_nine, port_out_eight};
  assign irq_pin_port_oe  = {port_oe_nine, port_oe_eight};

  // Pins eight and nine: port, timer clock or interrupt input.
  // The prohibited 11 code matches no branch, so the pin is then idle:
  // not driven, and every function sees its inactive level.
  generate
    for (i = 0; i < 2; i = i + 1) begin : g_irq_pin
      wire [1:0] mode;                      // This pin's mode code
      wire       is_port;                   // Port I/O selected
      wire       is_timer;                  // Timer external clock selected
      wire       is_irq;                    // Interrupt request selected
      assign mode     = irq_pin_mode[2*i +: 2];
      assign is_port  = (mode == `PAFS_MODE_PORT);  // RULE1 RULE2
      assign is_timer = (mode == `PAFS_MODE_TIMER); // RULE1 RULE2
      assign is_irq   = (mode == `PAFS_MODE_IRQ);   // RULE1 RULE2
      // The port logic keeps its output value; only the enable is gated
      assign irq_pin_out[i]     = irq_pin_port_out[i];
      assign irq_pin_oe[i]      = is_port & irq_pin_port_oe[i]; // RULE1 RULE2
      assign irq_pin_port_in[i] = is_port & irq_pin_pad[i];     // RULE1 RULE2
      assign irq_pin_timer[i]   = is_timer & irq_pin_pad[i];    // RULE1 RULE2
      // Interrupt inputs idle high so a deselected pin never looks like a low request
      assign irq_pin_irq[i]     = is_irq ? irq_pin_pad[i] : 1'b1; // RULE1 RULE2
    end
  endgenerate

  // Hand the loop results to the named ports
  assign port_pin_eight_o    = irq_pin_out[0];
  assign port_pin_eight_oe   = irq_pin_oe[0];      // RULE2
  assign port_in_eight       = irq_pin_port_in[0]; // RULE2
  assign timer_ext_clock_c   = irq_pin_timer[0];   // RULE2
  assign ext_interrupt_two   = irq_pin_irq[0];     // RULE2
  assign port_pin_nine_o     = irq_pin_out[1];
  assign port_pin_nine_oe    = irq_pin_oe[1];      // RULE1
  assign port_in_nine        = irq_pin_port_in[1]; // RULE1
  assign timer_ext_clock_d   = irq_pin_timer[1];   // RULE1
  assign ext_interrupt_three = irq_pin_irq[1];     // RULE1

  // Pin seven: port, timer clock B, or chip select three driven out.
  // Code 10 carries the chip select; 11 leaves the pin idle like the others.
  assign seven_is_port     = (pin_seven_mode == `PAFS_MODE_PORT);  // RULE3
  assign seven_is_timer    = (pin_seven_mode == `PAFS_MODE_TIMER); // RULE3
  assign seven_is_select   = (pin_seven_mode == `PAFS_MODE_CS);    // RULE3
  // The chip select reaches the pad with no flop, so bus timing is not stretched
  assign port_pin_seven_o  = seven_is_select ? chip_select_three_b : port_out_seven; // RULE3
  assign port_pin_seven_oe = seven_is_select | (seven_is_port & port_oe_seven);     // RULE3
  assign port_in_seven     = seven_is_port & port_pin_seven_i;                      // RULE3
  assign timer_ext_clock_b = seven_is_timer & port_pin_seven_i;                     // RULE3

  // Pin ten: port or chip select zero output.
  // In chip select mode the pad is always driven, whatever the port enable
  // says, because the select is an output of the bus controller.
  assign port_pin_ten_o  = pin_ten_mode ? chip_select_zero_b : port_out_ten;               // RULE6
  assign port_pin_ten_oe = pin_ten_mode | port_oe_ten;                                     // RULE6
  assign port_in_ten     = ~pin_ten_mode & port_pin_ten_i;                                 // RULE6

endmodule // pafs_pin_mux
`default_nettype wire

// *** verif/pafs_pin_mux_properties.sv ***
// Port-level properties of the port A pin-function block
`timescale 1ns/1ps
`default_nettype none
module pafs_pin_mux_props (
  // Clock, reset and bus handshake
  input wire logic clk,
  input wire logic rst_b,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_ack_o,
  // Pad values and the functions fed from them
  input wire logic port_pin_nine_i,
  input wire logic port_in_nine,
  input wire logic timer_ext_clock_d,
  input wire logic ext_interrupt_three,
  input wire logic port_pin_eight_i,
  input wire logic port_in_eight,
  input wire logic timer_ext_clock_c,
  input wire logic ext_interrupt_two,
  input wire logic port_pin_seven_i,
  input wire logic port_in_seven,
  input wire logic timer_ext_clock_b,
  // Pads driven out and their sources
  input wire logic port_pin_seven_o,
  input wire logic port_pin_seven_oe,
  input wire logic port_oe_seven,
  input wire logic chip_select_three_b,
  input wire logic port_pin_ten_o,
  input wire logic port_pin_ten_oe,
  input wire logic port_oe_ten,
  input wire logic chip_select_zero_b
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_b);
  // Only one consumer may see a pad at a time; idle irq lines rest high
  a_nine_port: assert property (
    port_in_nine |-> port_pin_nine_i && ext_interrupt_three && !timer_ext_clock_d)
    else $error("pin nine port path leaks");
  a_nine_irq: assert property (
    !ext_interrupt_three |-> !port_pin_nine_i && !port_in_nine && !timer_ext_clock_d)
    else $error("pin nine irq path leaks");
  a_eight_port: assert property (
    port_in_eight |-> port_pin_eight_i && ext_interrupt_two && !timer_ext_clock_c)
    else $error("pin eight port path leaks");
  a_eight_irq: assert property (
    !ext_interrupt_two |-> !port_pin_eight_i && !port_in_eight && !timer_ext_clock_c)
    else $error("pin eight irq path leaks");
  a_seven_timer: assert property (
    timer_ext_clock_b |-> port_pin_seven_i && !port_in_seven)
    else $error("pin seven timer path leaks");
  // With the port enable off, a driven pad can only be the chip select
  a_ten_select: assert property (
    port_pin_ten_oe && !port_oe_ten |-> port_pin_ten_o == chip_select_zero_b)
    else $error("pin ten drives wrong source");
  // Every taken request is answered on the next edge
  a_ack_next: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("ack late");
  // With the port enable off, a driven pin seven can only be the chip select
  a_seven_select: assert property (
    port_pin_seven_oe && !port_oe_seven |-> port_pin_seven_o == chip_select_three_b)
    else $error("pin seven drives wrong source");
  // Ack is a single-cycle pulse
  a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack held");
endmodule // pafs_pin_mux_props
bind pafs_pin_mux pafs_pin_mux_props u_props (.*);
`default_nettype wire

// *** verif/tb_pafs_pin_mux.sv ***
// Self-checking bench for the port A pin-function block
`timescale 1ns/1ps
`default_nettype none
module tb_pafs_pin_mux;
  logic clk = 1'h0, rst_b = 1'h0, wb_cyc_i = 1'h0, wb_stb_i = 1'h0, wb_we_i = 1'h0, wb_ack_o;
  logic [3:0] wb_adr_i = 4'h0, wb_sel_i = 4'hF;
  logic [31:0] wb_dat_i = 32'h0, wb_dat_o, rd, v;
  logic port_pin_seven_i, port_pin_eight_i, port_pin_nine_i, port_pin_ten_i, chip_select_zero_b;
  logic port_out_seven, port_out_eight, port_out_nine, port_out_ten, wb_err_o;
  logic port_oe_seven, port_oe_eight, port_oe_nine, port_oe_ten = 1'h0, chip_select_three_b = 1'h1;
  logic port_pin_seven_o, port_pin_eight_o, port_pin_nine_o, port_pin_ten_o, port_in_ten;
  logic port_pin_seven_oe, port_pin_eight_oe, port_pin_nine_oe, port_pin_ten_oe, port_in_seven;
  logic port_in_eight, port_in_nine, timer_ext_clock_b, timer_ext_clock_c, timer_ext_clock_d;
  logic ext_interrupt_two, ext_interrupt_three;
  int mismatches = 0, num_checks = 0, cyc = 0, m, n, p;
  pafs_pin_mux dut (.*);
  always #2 clk = ~clk;
  // Hang guard; the sequence needs about sixty cycles
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc >= 2000) begin
      mismatches++;
      summarize();
    end
  end
  task summarize();
    $display("checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  task chk(input logic [31:0] got, exp);
    num_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("CHECK FAILED t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  // One classic single cycle, held until ack is sampled high
  task bus(input logic w, input logic [3:0] a, input logic [31:0] d);
    @(posedge clk);
    wb_cyc_i <= 1'h1;
    wb_stb_i <= 1'h1;
    wb_we_i <= w;
    wb_adr_i <= a;
    wb_dat_i <= d;
    do @(posedge clk); while (wb_ack_o !== 1'h1);
    rd = wb_dat_o;
    wb_cyc_i <= 1'h0;
    wb_stb_i <= 1'h0;
  endtask
  task rdc(input logic [3:0] a, input logic [31:0] e);
    bus(1'h0, a, 32'h0);
    chk(rd, e);
  endtask
  initial begin
    repeat (3) @(posedge clk);
    rst_b <= 1'h1;
    rdc(4'h0, 32'h0);
    rdc(4'h4, 32'h0);
    rdc(4'h8, 32'h0);
    chk(wb_err_o, 1'h0);
    // Walk every legal code, never the prohibited 11; pin eight runs one code
    // ahead of pin nine, and pin seven takes chip select three on the last pass
    for (m = 0; m < 3; m++) begin
      n = (m + 1) % 3;
      v = ((m % 2) << 4) | (m << 2) | n;
      bus(1'h1, 4'h0, v);
      bus(1'h1, 4'h4, m << 14);
      rdc(4'h0, v);
      rdc(4'h4, m << 14);
      for (p = 0; p < 2; p++) begin
        @(posedge clk);
        {port_pin_seven_i, port_pin_eight_i, port_pin_nine_i} <= {3{p[0]}};
        {port_pin_ten_i, chip_select_zero_b, chip_select_three_b} <= {3{p[0]}};
        {port_out_seven, port_out_eight, port_out_nine, port_out_ten} <= {4{~p[0]}};
        {port_oe_seven, port_oe_eight, port_oe_nine, port_oe_ten} <= {4{p[0]}};
        @(posedge clk);
        #1;
        chk(port_in_nine, m == 0 && p);
        chk(timer_ext_clock_d, m == 1 && p);
        chk(ext_interrupt_three, m == 2 ? p : 1);
        chk(port_in_eight, n == 0 && p);
        chk(timer_ext_clock_c, n == 1 && p);
        chk(ext_interrupt_two, n == 2 ? p : 1);
        chk(port_pin_nine_oe, m == 0 && p);
        chk(port_pin_nine_o, !p);
        chk(port_pin_eight_oe, n == 0 && p);
        chk(port_pin_eight_o, !p);
        chk(port_in_seven, m == 0 && p);
        chk(timer_ext_clock_b, m == 1 && p);
        chk(port_pin_seven_o, m == 2 ? p : !p);
        chk(port_pin_seven_oe, m == 2 || (m == 0 && p));
        chk(port_pin_ten_o, m == 1 ? p : !p);
        chk(port_pin_ten_oe, m == 1 || p);
        chk(port_in_ten, m != 1 && p);
      end
    end
    summarize();
  end
endmodule // tb_pafs_pin_mux
`default_nettype wire
